// [hdl/dlc_pkg.sv]
// Constants for the data-link channel block: register offsets, field
// positions, reset values and link timing.
// Assumes an 8-bit register port with byte offsets as given below.
package dlc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_RX_LINK_BYTE = 8'h28;
   localparam logic [7:0] ADDR_MATCH_A = 8'h29;
   localparam logic [7:0] ADDR_MATCH_B = 8'h2A;
   localparam logic [7:0] ADDR_LINK_STATUS = 8'h40;
   localparam logic [7:0] ADDR_LINK_MASK = 8'h41;
   localparam logic [7:0] ADDR_LINK_CTRL = 8'h42;
   localparam logic [7:0] ADDR_TX_CHAN_BLK0 = 8'h43;
   localparam logic [7:0] ADDR_TX_SLOT_CTRL = 8'h92;
   localparam logic [7:0] ADDR_TX_SUPPRESS = 8'h93;
   // Number of channel block registers (24 channels, 8 per register)
   localparam int TX_CHAN_BLK_COUNT = 3;
   // Slot control fields
   localparam int POS_TS_ENABLE = 7;
   localparam int POS_UNASSIGNED = 6;
   localparam int POS_SELECT_MODE = 5;
   localparam int POS_SLOT_MSB = 4;
   localparam int POS_SLOT_LSB = 0;
   // Status and mask fields
   localparam int POS_BYTE_FULL = 4;
   localparam int POS_MATCH = 2;
   // Control fields
   localparam int POS_DESTUFF = 0;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Destuffer: a zero after exactly this many ones is removed
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam logic [2:0] RUN_SAT = 3'h6;
   // Index of the last bit in a link byte
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Link timing: one bit per frame, one byte per eight frames
   localparam int FRAME_US = 250;
   localparam int BYTE_US = FRAME_US * 8;
   localparam int CLK_MHZ = 40;
   localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
   localparam int BYTE_CYCLES = BYTE_US * CLK_MHZ;
endpackage : dlc_pkg

// [hdl/dlc_core.sv]
// Data-link channel block: transmit HDLC channel assignment and the
// legacy receive link byte path with match detection and destuffing.
// Assumes link bits and slot timing come from framer logic on clk.
// Assumes slot and bit indices change only just after a clock edge.
// Assumes the host never raises the write and read strobes together.
//
// Contract
// - Timeslot enable 0 gives HDLC the data link; 1 gives it DS0 channels.
// - Single channel number is slot control bits 4..0, bit 4 MSB.
// - Mode 0 uses channel field; mode 1 uses channel block registers.
// - Suppress register bit 7 is DS0 bit 8, bit 0 is DS0 bit 1.
// - A set suppress bit removes that DS0 bit from HDLC data.
// - Link or signaling frame bits shift one by one into link byte.
// - A full link byte completes every eight frames, 2 ms.
// - Filled link byte sets the byte-full flag.
// - Byte-full with mask enabled pulls the interrupt low.
// - Byte equal to either match byte sets the match flag.
// - Match with mask enabled pulls the interrupt low.
// - Zero destuffer works only when destuff enable is set.
// - A zero after exactly five ones is deleted.
// - A zero after six or more ones is kept.
// - Receive HDLC and legacy link path may run together.
// - HDLC may serve a DS0 while legacy path carries the link.
`timescale 1ns/1ps
module dlc_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Receive link bits from the framer
   input wire logic link_bit,
   input wire logic link_bit_valid,
   // Transmit slot timing from the framer
   input wire logic [4:0] tx_slot_index,
   input wire logic [2:0] tx_bit_index,
   // Transmit HDLC steering
   output logic tx_hdlc_on_link,
   output logic tx_hdlc_bit_select,
   // Interrupt
   output logic irq_n
);
   // Channel block bits, one for each channel that block mode can pick
   localparam int TX_BLK_BITS = dlc_pkg::TX_CHAN_BLK_COUNT * 8;

   // Register map, byte offsets of 8-bit registers
   // 0x28 received link byte, read only
   // 0x29 and 0x2A match bytes
   // 0x40 link status: bit 4 byte full, bit 2 match; a written 1 clears
   // 0x41 interrupt mask: bit 4 byte full, bit 2 match
   // 0x42 link control: bit 0 zero destuffer enable
   // 0x43 to 0x45 channel block: bit n of register k picks channel 8k+n
   // 0x92 slot control: bit 7 timeslot enable, bit 5 block mode, bits 4..0 channel
   // 0x93 bit suppress: bit 7 is the DS0 MSB, bit 0 its LSB
   // Unmapped offsets drop writes and read as zero
   //
   // Limitations
   // Block mode reaches channels 0 to 23 only; higher indices never hit
   // An unread byte is overwritten one byte time later without warning
   // The ones run spans byte boundaries, as the link is one bit stream
   // Frame timing is the framer's; this block counts valid pulses only
   // Destuffing acts on received link bits only, never on transmit data

   // All block state in one packed record
   typedef struct packed {
      // Transmit assignment registers
      logic [7:0] slot_ctrl;
      logic [7:0] suppress;
      logic [TX_BLK_BITS-1:0] chan_blk;
      // Match bytes
      logic [7:0] match_a;
      logic [7:0] match_b;
      // Link byte assembly and destuffer run
      logic [7:0] link_byte;
      logic [7:0] shift;
      logic [2:0] bit_count;
      logic [2:0] ones_run;
      // Status flags, masks and control
      logic full_flag;
      logic match_flag;
      logic full_mask;
      logic match_mask;
      logic destuff_en;
      // Registered outputs
      logic [7:0] rdata;
      logic irq_n;
      logic bit_select;
   } dlc_state_type;

   // Current and next copies of all block state
   dlc_state_type state;
   dlc_state_type next_state;

   // Outputs straight from state
   // No output is combinational from an input, so no path runs through
   assign reg_rdata = state.rdata;
   assign irq_n = state.irq_n;
   assign tx_hdlc_bit_select = state.bit_select;
   // Link position goes to HDLC only while timeslot enable is clear
   assign tx_hdlc_on_link = ~state.slot_ctrl[dlc_pkg::POS_TS_ENABLE];

   // Per-channel block decode, one bit per channel index
   // 32 entries so any five-bit channel index is a legal subscript
   logic [31:0] chan_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_chan
         if (gi < TX_BLK_BITS) begin : g_live
            assign chan_hit[gi] = state.chan_blk[gi];
         end else begin : g_none
            // No register holds channels past the block, so they never hit
            assign chan_hit[gi] = 1'b0;
         end
      end
   endgenerate

   // Next-state logic, in order: transmit select, link path, writes,
   // hardware sets, reads, interrupt. Sets follow the writes so a clear
   // in the same cycle loses, and the interrupt is taken from the final
   // flags so it moves on the same edge as a flag that sets.
   always_comb begin
      // Working values for this cycle
      logic [4:0] slot_num;
      logic slot_on;
      logic drop;
      logic [7:0] new_byte;
      logic full_set;
      logic match_set;
      logic full_irq;
      logic match_irq;
      slot_num = 5'h00;
      slot_on = 1'b0;
      drop = 1'b0;
      new_byte = 8'h00;
      full_set = 1'b0;
      match_set = 1'b0;
      full_irq = 1'b0;
      match_irq = 1'b0;
      // Every field holds unless a branch below changes it
      next_state = state;

      // Transmit slot selection
      slot_num = state.slot_ctrl[dlc_pkg::POS_SLOT_MSB:dlc_pkg::POS_SLOT_LSB];
      // Mode bit picks the single channel field or the block registers
      if (!state.slot_ctrl[dlc_pkg::POS_SELECT_MODE]) begin
         slot_on = (tx_slot_index == slot_num);
      end else begin
         slot_on = chan_hit[tx_slot_index];
      end
      // Bit index 7 is the MSB of the DS0, matching suppress bit 7
      next_state.bit_select = state.slot_ctrl[dlc_pkg::POS_TS_ENABLE] & slot_on
         & ~state.suppress[tx_bit_index];

      // Receive link path runs regardless of the HDLC assignment
      if (link_bit_valid) begin
         // Zero after exactly five ones is a stuffed bit
         drop = state.destuff_en & ~link_bit
            & (state.ones_run == dlc_pkg::STUFF_RUN);
         // Run saturates so a long run of ones never wraps back to five
         if (link_bit) begin
            if (state.ones_run != dlc_pkg::RUN_SAT) begin
               next_state.ones_run = state.ones_run + 3'h1;
            end
         end else begin
            next_state.ones_run = 3'h0;
         end
         // A dropped zero neither shifts nor counts
         if (!drop) begin
            // First bit received ends up as the LSB
            new_byte = {link_bit, state.shift[7:1]};
            next_state.shift = new_byte;
            // Byte completes on the eighth kept bit; the counter wraps to zero
            next_state.bit_count = state.bit_count + 3'h1;
            if (state.bit_count == dlc_pkg::LAST_BIT) begin
               // Unread byte is overwritten; host has one byte time
               next_state.link_byte = new_byte;
               full_set = 1'b1;
               match_set = (new_byte == state.match_a)
                  | (new_byte == state.match_b);
            end
         end
      end

      // Register writes; flag clears lose to a same-cycle set
      next_state.rdata = 8'h00;
      if (reg_wr) begin
         if (reg_addr == dlc_pkg::ADDR_TX_SLOT_CTRL) begin
            // Bit 6 is kept as written; software is expected to write zero
            next_state.slot_ctrl = reg_wdata;
         end else if (reg_addr == dlc_pkg::ADDR_TX_SUPPRESS) begin
            // New pattern applies from the next slot sample on
            next_state.suppress = reg_wdata;
         end else if (reg_addr == dlc_pkg::ADDR_MATCH_A) begin
            // Match bytes apply to the next completed byte, not the held one
            next_state.match_a = reg_wdata;
         end else if (reg_addr == dlc_pkg::ADDR_MATCH_B) begin
            // Second match byte, same timing as the first
            next_state.match_b = reg_wdata;
         end else if (reg_addr == dlc_pkg::ADDR_LINK_MASK) begin
            // Unmasking a pending flag pulls the interrupt on the next edge
            next_state.full_mask = reg_wdata[dlc_pkg::POS_BYTE_FULL];
            next_state.match_mask = reg_wdata[dlc_pkg::POS_MATCH];
         end else if (reg_addr == dlc_pkg::ADDR_LINK_CTRL) begin
            // A change mid-run leaves the ones run as it stands
            next_state.destuff_en = reg_wdata[dlc_pkg::POS_DESTUFF];
         end else if (reg_addr == dlc_pkg::ADDR_LINK_STATUS) begin
            // Write one to clear; a zero leaves its flag alone
            if (reg_wdata[dlc_pkg::POS_BYTE_FULL]) begin
               next_state.full_flag = 1'b0;
            end
            if (reg_wdata[dlc_pkg::POS_MATCH]) begin
               next_state.match_flag = 1'b0;
            end
         end else begin
            // Channel block registers sit at consecutive offsets
            for (int i = 0; i < dlc_pkg::TX_CHAN_BLK_COUNT; i++) begin
               if (reg_addr == dlc_pkg::ADDR_TX_CHAN_BLK0 + 8'(i)) begin
                  next_state.chan_blk[i*8 +: 8] = reg_wdata;
               end
            end
         end
      end
      // Hardware sets come after the writes so a new event is never lost
      if (full_set) begin
         next_state.full_flag = 1'b1;
      end
      if (match_set) begin
         next_state.match_flag = 1'b1;
      end

      // Register reads, data valid the following cycle
      // Data stand for one cycle only, then fall back to zero
      if (reg_rd) begin
         if (reg_addr == dlc_pkg::ADDR_TX_SLOT_CTRL) begin
            next_state.rdata = state.slot_ctrl;
         end else if (reg_addr == dlc_pkg::ADDR_TX_SUPPRESS) begin
            next_state.rdata = state.suppress;
         end else if (reg_addr == dlc_pkg::ADDR_RX_LINK_BYTE) begin
            // Reading leaves both flags set; software clears them by a write
            next_state.rdata = state.link_byte;
         end else if (reg_addr == dlc_pkg::ADDR_MATCH_A) begin
            next_state.rdata = state.match_a;
         end else if (reg_addr == dlc_pkg::ADDR_MATCH_B) begin
            next_state.rdata = state.match_b;
         end else if (reg_addr == dlc_pkg::ADDR_LINK_STATUS) begin
            // Undefined bits read as zero
            next_state.rdata[dlc_pkg::POS_BYTE_FULL] = state.full_flag;
            next_state.rdata[dlc_pkg::POS_MATCH] = state.match_flag;
         end else if (reg_addr == dlc_pkg::ADDR_LINK_MASK) begin
            next_state.rdata[dlc_pkg::POS_BYTE_FULL] = state.full_mask;
            next_state.rdata[dlc_pkg::POS_MATCH] = state.match_mask;
         end else if (reg_addr == dlc_pkg::ADDR_LINK_CTRL) begin
            next_state.rdata[dlc_pkg::POS_DESTUFF] = state.destuff_en;
         end else begin
            // Unmapped offsets find no match here and read as zero
            for (int i = 0; i < dlc_pkg::TX_CHAN_BLK_COUNT; i++) begin
               if (reg_addr == dlc_pkg::ADDR_TX_CHAN_BLK0 + 8'(i)) begin
                  next_state.rdata = state.chan_blk[i*8 +: 8];
               end
            end
         end
      end

      // Interrupt follows the masked flags, low while any is pending
      full_irq = next_state.full_flag & next_state.full_mask;
      match_irq = next_state.match_flag & next_state.match_mask;
      next_state.irq_n = ~(full_irq | match_irq);
   end

   // State register
   // All state moves on every edge; there is no clock enable
   always_ff @(posedge clk) begin
      if (rst) begin
         // Every field named so the reset values sit in one place
         state.slot_ctrl <= dlc_pkg::RESET_BYTE;
         state.suppress <= dlc_pkg::RESET_BYTE;
         state.chan_blk <= {dlc_pkg::TX_CHAN_BLK_COUNT{dlc_pkg::RESET_BYTE}};
         state.match_a <= dlc_pkg::RESET_BYTE;
         state.match_b <= dlc_pkg::RESET_BYTE;
         state.link_byte <= dlc_pkg::RESET_BYTE;
         state.shift <= dlc_pkg::RESET_BYTE;
         state.bit_count <= 3'h0;
         state.ones_run <= 3'h0;
         state.full_flag <= 1'b0;
         state.match_flag <= 1'b0;
         state.full_mask <= 1'b0;
         state.match_mask <= 1'b0;
         state.destuff_en <= 1'b0;
         state.rdata <= dlc_pkg::RESET_BYTE;
         state.irq_n <= 1'b1;
         state.bit_select <= 1'b0;
      end else begin
         state <= next_state;
      end
   end
endmodule : dlc_core

// [verif/dlc_core_properties.sv]
// Checker for dlc_core, bound to the top module.
// Assumes it sees only the top ports; it shadows the tx slot control and suppress registers.
`timescale 1ns/1ps
module dlc_core_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Link and transmit steering
   input wire logic link_bit_valid,
   input wire logic [4:0] tx_slot_index,
   input wire logic [2:0] tx_bit_index,
   input wire logic tx_hdlc_on_link,
   input wire logic tx_hdlc_bit_select,
   input wire logic irq_n
);
   logic [7:0] sh_slot;
   logic [7:0] sh_sup;
   logic sel_hit;
   // Shadows land on the same edge as the design's registers
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_slot <= 8'h00;
         sh_sup <= 8'h00;
      end else if (reg_wr && reg_addr == dlc_pkg::ADDR_TX_SLOT_CTRL) begin
         sh_slot <= reg_wdata;
      end else if (reg_wr && reg_addr == dlc_pkg::ADDR_TX_SUPPRESS) begin
         sh_sup <= reg_wdata;
      end
   end
   // Single-slot hit only; block mode is left to the bench
   assign sel_hit = sh_slot[7] && sh_slot[4:0] == tx_slot_index && !sh_sup[tx_bit_index];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Bench spaces a write and the following read by one idle cycle
   sequence match_wr;
      reg_wr && reg_addr == dlc_pkg::ADDR_MATCH_A;
   endsequence
   sequence match_rd;
      reg_rd && reg_addr == dlc_pkg::ADDR_MATCH_A;
   endsequence
   a_match_readback: assert property (match_wr ##2 match_rd |=>
      reg_rdata == $past(reg_wdata, 3)) else $error("match byte readback wrong");
   a_slot_readback: assert property (reg_rd && reg_addr == dlc_pkg::ADDR_TX_SLOT_CTRL
      |=> reg_rdata == $past(sh_slot)) else $error("slot control readback wrong");
   a_supp_readback: assert property (reg_rd && reg_addr == dlc_pkg::ADDR_TX_SUPPRESS
      |=> reg_rdata == $past(sh_sup)) else $error("suppress readback wrong");
   a_link_owner: assert property (tx_hdlc_on_link == !sh_slot[7])
      else $error("link steering disagrees with enable");
   a_link_quiet: assert property (tx_hdlc_on_link |=> !tx_hdlc_bit_select)
      else $error("slot selected while serving link");
   a_slot_pick: assert property (!$past(sh_slot[5]) |->
      tx_hdlc_bit_select == $past(sel_hit)) else $error("bit select wrong");
   a_irq_fall: assert property ($fell(irq_n) |->
      $past(link_bit_valid) || $past(reg_wr)) else $error("interrupt fell without cause");
   a_irq_rise: assert property ($rose(irq_n) |-> $past(reg_wr))
      else $error("interrupt released without host write");
endmodule : dlc_core_properties
bind dlc_core dlc_core_properties u_props (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .link_bit_valid(link_bit_valid), .tx_slot_index(tx_slot_index),
   .tx_bit_index(tx_bit_index), .tx_hdlc_on_link(tx_hdlc_on_link),
   .tx_hdlc_bit_select(tx_hdlc_bit_select), .irq_n(irq_n)
);

// [verif/dlc_link_src.sv]
// Framer-side model: hands link bits to the block one pulse at a time.
// Assumes the bench calls send; frames are shortened to two cycles.
`timescale 1ns/1ps
module dlc_link_src (
   // Clock
   input wire logic clk,
   // Link bits toward the block
   output logic link_bit = 1'b0,
   output logic link_bit_valid = 1'b0
);
   // LSB first; idle line shows the inverse so stale data never passes
   task send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         link_bit <= bits[i];
         link_bit_valid <= 1'b1;
         @(posedge clk);
         link_bit_valid <= 1'b0;
         link_bit <= ~bits[i];
      end
   endtask : send
endmodule : dlc_link_src

// [verif/dlc_core_bench.sv]
// Bench for dlc_core: register tasks, link traffic and tx steering.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module dlc_core_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] tx_slot_index = 5'h00;
   logic [2:0] tx_bit_index = 3'h0;
   logic [7:0] reg_rdata;
   logic link_bit;
   logic link_bit_valid;
   logic tx_hdlc_on_link;
   logic tx_hdlc_bit_select;
   logic irq_n;
   int miscompares = 0;
   int n_tests = 0;
   logic [7:0] bytes_in [3] = '{8'hA5, 8'h7E, 8'hDF};
   logic [7:0] stat_in [3] = '{8'h10, 8'h14, 8'h14};
   dlc_core u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_bit(link_bit),
      .link_bit_valid(link_bit_valid), .tx_slot_index(tx_slot_index),
      .tx_bit_index(tx_bit_index), .tx_hdlc_on_link(tx_hdlc_on_link),
      .tx_hdlc_bit_select(tx_hdlc_bit_select), .irq_n(irq_n));
   dlc_link_src u_src (.clk(clk), .link_bit(link_bit), .link_bit_valid(link_bit_valid));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // Strobes drop on the second edge, so a following call never collides
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("read data", exp, reg_rdata);
   endtask : rd
   // Sweep slots 4 and 5; only slot hit may carry bits 2..7 of the DS0
   task steer(input int hit);
      for (int s = 4; s < 6; s++) begin
         for (int b = 0; b < 8; b++) begin
            @(posedge clk);
            tx_slot_index <= s[4:0];
            tx_bit_index <= b[2:0];
            @(posedge clk);
            #1 chk("bit select", {7'h00, s == hit && b != 0 && b != 7},
               {7'h00, tx_hdlc_bit_select});
         end
      end
   endtask : steer
   task results;
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Whole run is well under 2000 cycles
   initial begin
      #50000;
      miscompares++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(dlc_pkg::ADDR_TX_SLOT_CTRL, 8'h00);
      rd(dlc_pkg::ADDR_TX_SUPPRESS, 8'h00);
      rd(8'hFF, 8'h00);
      wr(dlc_pkg::ADDR_MATCH_A, 8'h7E);
      rd(dlc_pkg::ADDR_MATCH_A, 8'h7E);
      wr(dlc_pkg::ADDR_MATCH_B, 8'hDF);
      wr(dlc_pkg::ADDR_LINK_MASK, 8'h14);
      rd(dlc_pkg::ADDR_LINK_MASK, 8'h14);
      for (int i = 0; i < 3; i++) begin
         u_src.send({8'h00, bytes_in[i]}, 8);
         #1 chk("interrupt", 8'h00, {7'h00, irq_n});
         rd(dlc_pkg::ADDR_RX_LINK_BYTE, bytes_in[i]);
         rd(dlc_pkg::ADDR_LINK_STATUS, stat_in[i]);
         wr(dlc_pkg::ADDR_LINK_STATUS, 8'h14);
         #1 chk("interrupt", 8'h01, {7'h00, irq_n});
      end
      wr(dlc_pkg::ADDR_LINK_MASK, 8'h00);
      wr(dlc_pkg::ADDR_LINK_CTRL, 8'h01);
      rd(dlc_pkg::ADDR_LINK_CTRL, 8'h01);
      // Leading zero ends the ones run left over from the last byte
      u_src.send(16'h01BE, 9);
      #1 chk("interrupt", 8'h01, {7'h00, irq_n});
      rd(dlc_pkg::ADDR_RX_LINK_BYTE, 8'hFE);
      u_src.send(16'h00BF, 8);
      rd(dlc_pkg::ADDR_RX_LINK_BYTE, 8'hBF);
      wr(dlc_pkg::ADDR_TX_SLOT_CTRL, 8'h85);
      wr(dlc_pkg::ADDR_TX_SUPPRESS, 8'h81);
      #1 chk("link steering", 8'h00, {7'h00, tx_hdlc_on_link});
      steer(5);
      wr(dlc_pkg::ADDR_TX_CHAN_BLK0, 8'h10);
      rd(dlc_pkg::ADDR_TX_CHAN_BLK0, 8'h10);
      wr(dlc_pkg::ADDR_TX_SLOT_CTRL, 8'hA5);
      steer(4);
      wr(dlc_pkg::ADDR_TX_SLOT_CTRL, 8'h05);
      #1 chk("link steering", 8'h01, {7'h00, tx_hdlc_on_link});
      steer(-1);
      results();
   end
endmodule : dlc_core_bench
